// ---- core/system_reset_sequencer.v ----
// reset source gathering and release sequencing with an apb register file
// How it works
// - power-on or supply dip makes a cold reset, every other source warm
// - cold reset loads the clock source from the boot clock select field
// - warm reset keeps the current clock select, read at bits 14 to 12
// - core stays in reset until supplies are good and clock is ready
// - each oscillator mode picks its own mix of start, timer and lock waits
// - start-up timer counts 1024 oscillator periods for crystal sources
// - pll modes add a lock wait of 1.5 ms
// - power-on reset holds until threshold, then 30 us extension
// - dip reset holds while supply low, then 100 us extension
// - power-up timer extends reset, release then enables the oscillator
// - power-up delay chosen by a three-bit field, eight settings to 128 ms
// - dip extension and power-up delay restart on every supply recovery
// - after clock ready the core fetches from address zero
// - clock-fail monitor starts 900 us after clock ready when enabled
// - power-on reset sets cause bit 0
// - dip reset sets cause bit 1
// - master clear low longer than the filter resets, short pulses ignored
// - master clear reset sets the pin reset flag
// - soft reset pulses the line for one cycle, clock kept, then fetch
// - soft reset sets cause bit 6
// - any active source asserts the system reset line
// - power-on reset clears every cause flag but the power-on flag
// - software sets or clears cause flags without causing a reset
//
// Register access over APB and the register addresses were decided locally.
`include "system_reset_sequencer_consts.vh"
`default_nettype none
module system_reset_sequencer #(
  parameter POWER_ON_EXT_CYC = `POWER_ON_EXT_CYC,
  parameter DIP_EXT_CYC = `DIP_EXT_CYC,
  parameter PLL_LOCK_CYC = `PLL_LOCK_CYC,
  parameter MON_DELAY_CYC = `MON_DELAY_CYC,
  parameter MS_CYC = `MS_CYC,
  parameter LOW_POWER_RC_OSD_CYC = `LOW_POWER_RC_OSD_CYC,
  parameter FAST_RC_OSD_CYC = `FAST_RC_OSD_CYC,
  parameter PIN_FILTER_CYC = `PIN_FILTER_CYC
) (
  input wire core_clk_in, // 200 MHz clock
  input wire reset_in, // synchronous reset, active high
  input wire power_on_ok_in, // supply above power-on threshold, async
  input wire supply_ok_in, // supply above dip threshold, async
  input wire master_clear_pin_n_in, // master clear pin, active low, async
  input wire osc_clk_in, // selected oscillator clock, async
  input wire soft_reset_in, // reset instruction executed, one-cycle pulse
  input wire psel_in, // apb select
  input wire penable_in, // apb enable
  input wire pwrite_in, // apb write
  input wire [7:0] paddr_in, // apb byte address
  input wire [31:0] pwdata_in, // apb write data
  output wire pready_out, // apb ready
  output reg [31:0] prdata_out, // apb read data
  output wire pslverr_out, // apb error on unmapped address
  output reg system_reset_line_out, // system reset line, active high
  output reg core_reset_out, // core held in reset, active high
  output reg osc_enable_out, // selected oscillator may run
  output reg [2:0] clock_select_out, // clock source in use
  output reg fetch_start_out, // one-cycle pulse, begin vector fetch
  output reg [23:0] fetch_address_out, // vector fetch address
  output reg monitor_active_out // clock-fail monitor supervising
);
  // ============================================================
  // states
  localparam S_POWER = 4'h0;
  localparam S_DIP = 4'h1;
  localparam S_DIP_EXT = 4'h2;
  localparam S_POWERUP_TIMER = 4'h3;
  localparam S_OSC_DLY = 4'h4;
  localparam S_OST = 4'h5;
  localparam S_LOCK = 4'h6;
  localparam S_RUN = 4'h7;
  localparam S_PIN = 4'h8;
  localparam S_SOFT = 4'h9;

  // ============================================================
  // functions
  // waits needed by a source: {start delay, start-up timer, pll lock}
  function [2:0] osc_needs;
    input [2:0] src;
    input [1:0] pri;
    reg ext;
    begin
      ext = (pri == `PRI_EXTERNAL);
      case (src)
        `SRC_FAST_RC_PLL: osc_needs = 3'h5;
        `SRC_PRIMARY: osc_needs = ext ? 3'h0 : 3'h6;
        `SRC_PRIMARY_PLL: osc_needs = ext ? 3'h1 : 3'h7;
        `SRC_SECONDARY: osc_needs = 3'h6;
        default: osc_needs = 3'h4;
      endcase
    end
  endfunction

  // power-up delay in milliseconds per setting
  function [7:0] powerup_timer_ms;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: powerup_timer_ms = 8'h00;
        3'h1: powerup_timer_ms = 8'h02;
        3'h2: powerup_timer_ms = 8'h04;
        3'h3: powerup_timer_ms = 8'h08;
        3'h4: powerup_timer_ms = 8'h10;
        3'h5: powerup_timer_ms = 8'h20;
        3'h6: powerup_timer_ms = 8'h40;
        default: powerup_timer_ms = 8'h80;
      endcase
    end
  endfunction

  // ============================================================
  // input synchronisers
  reg [1:0] pon_sync_q, sup_sync_q, pin_sync_q, osc_sync_q;
  reg osc_prev_q;
  // two flip-flops on every asynchronous input
  always @(posedge core_clk_in) begin
    pon_sync_q <= {pon_sync_q[0], power_on_ok_in};
    sup_sync_q <= {sup_sync_q[0], supply_ok_in};
    pin_sync_q <= {pin_sync_q[0], master_clear_pin_n_in};
    osc_sync_q <= {osc_sync_q[0], osc_clk_in};
    osc_prev_q <= osc_sync_q[1];
  end
  wire power_ok = pon_sync_q[1];
  wire supply_ok = sup_sync_q[1];
  wire osc_edge = osc_sync_q[1] & ~osc_prev_q;

  // ============================================================
  // master clear glitch filter
  reg [7:0] pin_cnt_q;
  wire pin_active = (pin_cnt_q == PIN_FILTER_CYC[7:0]);
  // low level must persist for the filter length
  always @(posedge core_clk_in) begin
    if (reset_in | pin_sync_q[1]) begin
      pin_cnt_q <= 8'h00;
    end else if (!pin_active) begin
      pin_cnt_q <= pin_cnt_q + 8'h01;
    end
  end

  // ============================================================
  // registers
  reg [7:0] cause_q;
  reg [15:0] cfg_q;
  reg [2:0] cur_clk_q;
  reg cold_q;
  reg [3:0] state_q, state_d;
  reg [31:0] cnt_q, cnt_d;
  reg [7:0] ms_q, ms_d;
  reg [9:0] ost_q, ost_d;
  reg [31:0] mon_cnt_q;
  reg [7:0] cause_set;
  reg cause_por;
  wire [2:0] boot_sel = cfg_q[`CFG_BOOT_LSB +: 3];
  wire [1:0] pri_kind = cfg_q[`CFG_PRIMARY_LSB +: 2];
  wire [2:0] powerup_timer_sel = cfg_q[`CFG_POWERUP_TIMER_LSB +: 3];
  wire [2:0] src_next = cold_q ? boot_sel : cur_clk_q;
  wire [2:0] needs = osc_needs(cur_clk_q, pri_kind);
  wire [31:0] osd_cyc = (cur_clk_q == `SRC_LOW_POWER_RC) ? LOW_POWER_RC_OSD_CYC
                                                         : FAST_RC_OSD_CYC;

  // ============================================================
  // sequencer next state
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q + 32'h1;
    ms_d = ms_q;
    ost_d = ost_q;
    cause_set = 8'h00;
    cause_por = 1'b0;
    if (!power_ok) begin
      state_d = S_POWER;
      cnt_d = 32'h0;
      cause_por = 1'b1;
    end else if (!supply_ok && state_q != S_POWER) begin
      state_d = S_DIP;
      cnt_d = 32'h0;
      cause_set[`CAUSE_DIP] = 1'b1;
    end else begin
      case (state_q)
        S_POWER: begin
          if (cnt_q >= POWER_ON_EXT_CYC - 1) begin
            state_d = S_DIP_EXT;
            cnt_d = 32'h0;
          end
        end
        S_DIP: begin
          state_d = S_DIP_EXT;
          cnt_d = 32'h0;
        end
        S_DIP_EXT: begin
          if (cnt_q >= DIP_EXT_CYC - 1) begin
            state_d = S_POWERUP_TIMER;
            cnt_d = 32'h0;
            ms_d = 8'h00;
          end
        end
        S_POWERUP_TIMER: begin
          if (ms_q >= powerup_timer_ms(powerup_timer_sel)) begin
            state_d = S_OSC_DLY;
            cnt_d = 32'h0;
          end else if (cnt_q >= MS_CYC - 1) begin
            cnt_d = 32'h0;
            ms_d = ms_q + 8'h01;
          end
        end
        S_OSC_DLY: begin
          if (!needs[2] || cnt_q >= osd_cyc - 1) begin
            state_d = S_OST;
            ost_d = 10'h000;
          end
        end
        S_OST: begin
          if (!needs[1] || (osc_edge && ost_q == 10'h3FF)) begin
            state_d = S_LOCK;
            cnt_d = 32'h0;
          end else if (osc_edge) begin
            ost_d = ost_q + 10'h001;
          end
        end
        S_LOCK: begin
          if (!needs[0] || cnt_q >= PLL_LOCK_CYC - 1) begin
            state_d = S_RUN;
          end
        end
        S_RUN: begin
          if (soft_reset_in) begin
            state_d = S_SOFT;
            cause_set[`CAUSE_SOFT] = 1'b1;
          end else if (pin_active) begin
            state_d = S_PIN;
            cause_set[`CAUSE_PIN] = 1'b1;
          end
        end
        S_PIN: begin
          if (!pin_active) begin
            state_d = S_RUN;
          end
        end
        S_SOFT: begin
          state_d = S_RUN;
        end
        default: begin
          state_d = S_POWER;
        end
      endcase
    end
  end

  // ============================================================
  // sequencer state and outputs
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      state_q <= S_POWER;
      cnt_q <= 32'h0;
      ms_q <= 8'h00;
      ost_q <= 10'h000;
      cold_q <= 1'b1;
      cur_clk_q <= `SRC_FAST_RC;
      system_reset_line_out <= 1'b1;
      core_reset_out <= 1'b1;
      osc_enable_out <= 1'b0;
      fetch_start_out <= 1'b0;
      fetch_address_out <= `RESET_VECTOR;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ms_q <= ms_d;
      ost_q <= ost_d;
      if (state_d == S_POWER || state_d == S_DIP) begin
        cold_q <= 1'b1;
      end else if (state_d == S_PIN || state_d == S_SOFT) begin
        cold_q <= 1'b0;
      end
      // source is chosen as the line is released
      if (state_q == S_POWERUP_TIMER && state_d == S_OSC_DLY) begin
        cur_clk_q <= src_next;
      end
      system_reset_line_out <= (state_d <= S_POWERUP_TIMER) || state_d == S_PIN
                               || state_d == S_SOFT;
      osc_enable_out <= (state_d > S_POWERUP_TIMER);
      core_reset_out <= (state_d != S_RUN);
      fetch_start_out <= (state_d == S_RUN) && (state_q != S_RUN);
      fetch_address_out <= `RESET_VECTOR;
    end
  end

  // ============================================================
  // clock-fail monitor start delay
  always @(posedge core_clk_in) begin
    if (reset_in || state_q != S_RUN || !cfg_q[`CFG_MON_EN]) begin
      mon_cnt_q <= 32'h0;
      monitor_active_out <= 1'b0;
    end else if (mon_cnt_q >= MON_DELAY_CYC - 1) begin
      monitor_active_out <= 1'b1;
    end else begin
      mon_cnt_q <= mon_cnt_q + 32'h1;
    end
  end

  // clock source in use follows the current select
  always @* begin
    clock_select_out = cur_clk_q;
  end

  // ============================================================
  // apb slave, zero wait states, read data captured in setup
  wire setup = psel_in & ~penable_in;
  wire wr_acc = psel_in & penable_in & pwrite_in;
  wire mapped = (paddr_in == `REG_RESET_CAUSE) || (paddr_in == `REG_OSC_CONTROL)
                || (paddr_in == `REG_CONFIG) || (paddr_in == `REG_STATUS);
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~mapped;

  // cause flags: hardware set wins over a software write
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      cause_q <= `CAUSE_RESET_VAL;
    end else if (cause_por) begin
      cause_q <= 8'h01 << `CAUSE_POWER_ON;
    end else if (wr_acc && paddr_in == `REG_RESET_CAUSE) begin
      cause_q <= (pwdata_in[7:0] & 8'hC3) | cause_set;
    end else begin
      cause_q <= cause_q | cause_set;
    end
  end

  // configuration shadow written by software
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      cfg_q <= `CFG_RESET_VAL;
    end else if (wr_acc && paddr_in == `REG_CONFIG) begin
      cfg_q <= pwdata_in[15:0] & 16'h1737;
    end
  end

  // read data register
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      prdata_out <= 32'h0;
    end else if (setup) begin
      case (paddr_in)
        `REG_RESET_CAUSE: prdata_out <= {24'h0, cause_q};
        `REG_OSC_CONTROL: prdata_out <= {17'h0, cur_clk_q, 12'h0};
        `REG_CONFIG: prdata_out <= {16'h0, cfg_q};
        `REG_STATUS: prdata_out <= {24'h0, cold_q, monitor_active_out,
                                    core_reset_out, system_reset_line_out,
                                    state_q};
        default: prdata_out <= 32'h0;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- core/system_reset_sequencer_consts.vh ----
// constants for the system reset sequencer
`ifndef SYSTEM_RESET_SEQUENCER_CONSTS_VH
`define SYSTEM_RESET_SEQUENCER_CONSTS_VH
// ============================================================
// register byte offsets
`define REG_RESET_CAUSE 8'h00
`define REG_OSC_CONTROL 8'h04
`define REG_CONFIG 8'h08
`define REG_STATUS 8'h0C
// ============================================================
// reset cause flag positions and value after reset
`define CAUSE_POWER_ON 0
`define CAUSE_DIP 1
`define CAUSE_SOFT 6
`define CAUSE_PIN 7
`define CAUSE_RESET_VAL 8'h03
// ============================================================
// field positions
`define CUR_CLK_LSB 12
`define CFG_BOOT_LSB 0
`define CFG_PRIMARY_LSB 4
`define CFG_POWERUP_TIMER_LSB 8
`define CFG_MON_EN 12
`define CFG_RESET_VAL 16'h1000
// ============================================================
// clock source codes
`define SRC_FAST_RC 3'h0
`define SRC_FAST_RC_PLL 3'h1
`define SRC_PRIMARY 3'h2
`define SRC_PRIMARY_PLL 3'h3
`define SRC_SECONDARY 3'h4
`define SRC_LOW_POWER_RC 3'h5
`define SRC_FAST_RC_DIV16 3'h6
`define SRC_FAST_RC_DIVN 3'h7
// primary oscillator kinds
`define PRI_CRYSTAL 2'h0
`define PRI_HIGH_SPEED 2'h1
`define PRI_EXTERNAL 2'h2
// ============================================================
// times in their own units and derived cycle counts at the core clock
`define CLK_MHZ 200
`define POWER_ON_EXT_NS 30000
`define DIP_EXT_NS 100000
`define PLL_LOCK_NS 1500000
`define MON_DELAY_NS 900000
`define FAST_RC_OSD_NS 1100
`define LOW_POWER_RC_OSD_NS 70000
`define MS_NS 1000000
`define POWER_ON_EXT_CYC ((`POWER_ON_EXT_NS * `CLK_MHZ) / 1000)
`define DIP_EXT_CYC ((`DIP_EXT_NS * `CLK_MHZ) / 1000)
`define PLL_LOCK_CYC ((`PLL_LOCK_NS * `CLK_MHZ) / 1000)
`define MON_DELAY_CYC ((`MON_DELAY_NS * `CLK_MHZ) / 1000)
`define FAST_RC_OSD_CYC ((`FAST_RC_OSD_NS * `CLK_MHZ) / 1000)
`define LOW_POWER_RC_OSD_CYC ((`LOW_POWER_RC_OSD_NS * `CLK_MHZ) / 1000)
`define MS_CYC ((`MS_NS * `CLK_MHZ) / 1000)
`define OST_PERIODS 1024
`define PIN_FILTER_CYC 16
`define RESET_VECTOR 24'h000000
`endif

// ---- dv/reset_seq_monitor.sv ----
// checker on the ports of the reset sequencer
`default_nettype none
module reset_seq_monitor #(
  parameter MON_DELAY_CYC = 30,
  parameter PIN_FILTER_CYC = 4
) (
  input wire logic core_clk_in, // clock
  input wire logic reset_in, // sync reset
  input wire logic power_on_ok_in, // supply above power-on level
  input wire logic supply_ok_in, // supply above dip level
  input wire logic master_clear_pin_n_in, // pin, active low
  input wire logic soft_reset_in, // reset instruction
  input wire logic system_reset_line_out, // system reset
  input wire logic core_reset_out, // core reset
  input wire logic osc_enable_out, // oscillator enable
  input wire logic [2:0] clock_select_out, // clock source
  input wire logic fetch_start_out, // fetch pulse
  input wire logic [23:0] fetch_address_out, // fetch address
  input wire logic monitor_active_out // monitor on
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] run_q;
  logic [7:0] pin_low_q;
  logic pin_high_q;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  // ==========================================
  // helper counters
  // cycles out of reset, and length of the latest low run on the pin, kept after release
  always_ff @(posedge core_clk_in) begin
    if (reset_in || core_reset_out) run_q <= 8'h00;
    else if (run_q != 8'hFF) run_q <= run_q + 8'h01;
    pin_high_q <= reset_in || master_clear_pin_n_in;
    if (reset_in) pin_low_q <= 8'h00;
    else if (!master_clear_pin_n_in && pin_high_q) pin_low_q <= 8'h01;
    else if (!master_clear_pin_n_in && pin_low_q != 8'hFF) pin_low_q <= pin_low_q + 8'h01;
  end
  // ==========================================
  // assertions
  soft_pulse_a: assert property (
    soft_reset_in && !core_reset_out |=> system_reset_line_out && core_reset_out
    ##1 !system_reset_line_out && !core_reset_out && fetch_start_out)
    else $error("soft reset pulse wrong");
  soft_clock_a: assert property (
    soft_reset_in && !core_reset_out |=> $stable(clock_select_out) [*3])
    else $error("clock source changed on soft reset");
  vector_addr_a: assert property (
    fetch_start_out |-> fetch_address_out == 24'h000000 && !core_reset_out)
    else $error("bad fetch start");
  system_reset_line_core_a: assert property (
    system_reset_line_out |-> core_reset_out)
    else $error("core runs under system reset");
  osc_release_a: assert property (
    $fell(system_reset_line_out) |-> osc_enable_out)
    else $error("oscillator not enabled at release");
  dip_hold_a: assert property (
    !supply_ok_in [*5] |-> system_reset_line_out)
    else $error("no reset on supply dip");
  dip_ext_a: assert property (
    $rose(supply_ok_in) |-> system_reset_line_out [*8])
    else $error("dip extension too short");
  power_ext_a: assert property (
    $rose(power_on_ok_in) |-> system_reset_line_out [*8])
    else $error("power-on extension too short");
  pin_filter_a: assert property (
    $rose(system_reset_line_out) && supply_ok_in && !$past(soft_reset_in)
    |-> pin_low_q >= PIN_FILTER_CYC)
    else $error("reset without a long pin pulse");
  monitor_delay_a: assert property (
    $rose(monitor_active_out) |-> run_q >= MON_DELAY_CYC - 2 && run_q <= MON_DELAY_CYC + 4)
    else $error("monitor start delay wrong");
  // main scenarios reached
  soft_seen_c: cover property (soft_reset_in && !core_reset_out);
  pin_seen_c: cover property ($rose(system_reset_line_out) && supply_ok_in);
  mon_seen_c: cover property ($rose(monitor_active_out));
endmodule
`default_nettype wire

// ---- dv/clear_supervisor_model.sv ----
// outside supervisor that drives the master clear pin
`default_nettype none
module clear_supervisor_model (
  input wire logic core_clk_in, // reference clock
  output logic master_clear_pin_n_out // driven pin, active low
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // pin is always driven high when idle: it has no pull-up
  initial master_clear_pin_n_out = 1'b1;
  // hold the pin low for some cycles, entered just after an edge
  task automatic hold_low(input int cycles);
    master_clear_pin_n_out <= 1'b0;
    repeat (cycles) @(posedge core_clk_in);
    master_clear_pin_n_out <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// testbench for the system reset sequencer
`include "system_reset_sequencer_consts.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int s; int p; int w; int g;} row_t;
  logic core_clk_in = 1'b0, reset_in = 1'b1, power_on_ok_in = 1'b0, supply_ok_in = 1'b0;
  logic osc_clk_in = 1'b0, soft_reset_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  wire master_clear_pin_n_in, pready_out, pslverr_out, system_reset_line_out;
  wire core_reset_out, osc_enable_out, fetch_start_out, monitor_active_out;
  wire [2:0] clock_select_out;
  wire [31:0] prdata_out;
  wire [23:0] fetch_address_out;
  int failures = 0, n_checks = 0, n;
  logic [31:0] r;
  logic e;
  // source, primary kind, power-up select, supply glitch
  row_t rows[11] = '{'{0, 0, 0, 0}, '{1, 0, 1, 1}, '{2, 0, 2, 0}, '{2, 1, 3, 0},
    '{2, 2, 4, 0}, '{3, 0, 5, 0}, '{3, 2, 6, 0}, '{4, 0, 7, 0}, '{5, 0, 0, 0},
    '{6, 0, 0, 0}, '{7, 0, 1, 0}};
  // shortened waits; power-on extension, fast rc start and pin filter keep their defaults
  system_reset_sequencer #(.DIP_EXT_CYC(8), .PLL_LOCK_CYC(20), .MON_DELAY_CYC(30),
    .MS_CYC(16), .LOW_POWER_RC_OSD_CYC(6)) dut (.core_clk_in, .reset_in, .power_on_ok_in,
    .supply_ok_in, .master_clear_pin_n_in, .osc_clk_in, .soft_reset_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .prdata_out, .pslverr_out,
    .system_reset_line_out, .core_reset_out, .osc_enable_out, .clock_select_out,
    .fetch_start_out, .fetch_address_out, .monitor_active_out);
  clear_supervisor_model sup (.core_clk_in, .master_clear_pin_n_out(master_clear_pin_n_in));
  // ==========================================
  // clocks: core at 200 MHz, oscillator unrelated
  always #2.5 core_clk_in = ~core_clk_in;
  always #15.3 osc_clk_in = ~osc_clk_in;
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk_in);
      k++;
    end while (pready_out !== 1'b1 && k < 40);
    if (pready_out !== 1'b1) failures++;
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  // wait for the core to run, then for the monitor
  task automatic wait_run();
    n = 0;
    while (core_reset_out !== 1'b0 && n < 20000) begin
      @(posedge core_clk_in);
      n++;
    end
    for (int k = 0; k < 60 && monitor_active_out !== 1'b1; k++) @(posedge core_clk_in);
    chk(monitor_active_out, 1'b1);
  endtask
  // shortest boot after supply recovery
  function automatic int lo_cyc(input row_t x);
    int osd;
    int ost;
    int lk;
    osd = (x.s == 5) ? 6 : ((x.s == 2 || x.s == 3) && x.p == 2) ? 1 : `FAST_RC_OSD_CYC;
    ost = ((x.s == 2 || x.s == 3) && x.p != 2) || x.s == 4 ? 6260 : 1;
    lk = (x.s == 1 || x.s == 3) ? 20 : 1;
    return 8 + (x.w == 0 ? 1 : 16 << x.w) + osd + ost + lk;
  endfunction
  // configure, dip the supply, recover and boot
  task automatic boot(input row_t x);
    apb(1'b1, `REG_CONFIG, 32'h1000 | (x.w << 8) | (x.p << 4) | x.s);
    apb(1'b1, `REG_RESET_CAUSE, 32'h0);
    supply_ok_in <= 1'b0;
    repeat (10) @(posedge core_clk_in);
    if (x.g != 0) begin
      supply_ok_in <= 1'b1;
      repeat (5) @(posedge core_clk_in);
      supply_ok_in <= 1'b0;
      repeat (6) @(posedge core_clk_in);
    end
    supply_ok_in <= 1'b1;
    wait_run();
  endtask
  // report and end the run
  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog sized well above the expected run
  initial begin
    repeat (90000) @(posedge core_clk_in);
    failures++;
    close_out();
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (6) @(posedge core_clk_in);
    reset_in <= 1'b0;
    @(posedge core_clk_in);
    apb(1'b0, `REG_RESET_CAUSE, 32'h0);
    chk(r, 32'h01);
    chk(system_reset_line_out, 1'b1);
    supply_ok_in <= 1'b1;
    @(posedge core_clk_in);
    power_on_ok_in <= 1'b1;
    wait_run();
    chk(clock_select_out, 32'h0);
    apb(1'b0, `REG_RESET_CAUSE, 32'h0);
    chk(r & 32'hC1, 32'h01);
    foreach (rows[i]) begin
      boot(rows[i]);
      chk(n >= lo_cyc(rows[i]) && n <= lo_cyc(rows[i]) + 30, 1'b1);
      chk(clock_select_out, rows[i].s);
      apb(1'b0, `REG_RESET_CAUSE, 32'h0);
      chk(r, 32'h02);
    end
    apb(1'b0, `REG_STATUS, 32'h0);
    chk(r & 32'hC0, 32'hC0);
    apb(1'b1, `REG_RESET_CAUSE, 32'hC3);
    apb(1'b0, `REG_RESET_CAUSE, 32'h0);
    chk(r, 32'hC3);
    chk(core_reset_out, 1'b0);
    apb(1'b1, `REG_RESET_CAUSE, 32'h0);
    apb(1'b1, `REG_CONFIG, 32'h1000);
    soft_reset_in <= 1'b1;
    @(posedge core_clk_in);
    soft_reset_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    chk(clock_select_out, 32'h7);
    apb(1'b0, `REG_RESET_CAUSE, 32'h0);
    chk(r, 32'h40);
    apb(1'b0, `REG_OSC_CONTROL, 32'h0);
    chk(r, 32'h7000);
    apb(1'b1, `REG_RESET_CAUSE, 32'h0);
    sup.hold_low(`PIN_FILTER_CYC - 1);
    repeat (10) @(posedge core_clk_in);
    chk(core_reset_out, 1'b0);
    sup.hold_low(`PIN_FILTER_CYC + 8);
    chk(system_reset_line_out, 1'b1);
    wait_run();
    chk(clock_select_out, 32'h7);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk(r & 32'hC0, 32'h40);
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    chk(e, 1'b1);
    chk(core_reset_out, 1'b0);
    apb(1'b0, `REG_RESET_CAUSE, 32'h0);
    chk(r, 32'h80);
    close_out();
  end
endmodule
bind system_reset_sequencer reset_seq_monitor #(.MON_DELAY_CYC(MON_DELAY_CYC),
  .PIN_FILTER_CYC(PIN_FILTER_CYC)) mon (.core_clk_in, .reset_in, .power_on_ok_in,
  .supply_ok_in, .master_clear_pin_n_in, .soft_reset_in, .system_reset_line_out,
  .core_reset_out, .osc_enable_out, .clock_select_out, .fetch_start_out,
  .fetch_address_out, .monitor_active_out);
`default_nettype wire
